// ### logic/gptm_misc_regs.sv
`timescale 1ns/1ps
module gptm_misc_regs
  import gptm_pkg::*;
#(
  parameter int FREE_DIV_NUM = 5,                // Free counter adds 5 per 4 clocks at 20 MHz: 25 MHz rate
  parameter int FREE_DIV_DEN = 4,
  parameter int PHY_HOLD     = gptm_pkg::PHY_HOLD_CYCLES  // Hold of each port PHY reset
) (
  input  wire logic        clock,        // 20 MHz system clock
  input  wire logic        resetn,       // Asynchronous reset, active low
  input  wire logic        regWrite,     // Register write strobe
  input  wire logic        regRead,      // Register read strobe
  input  wire logic [1:0]  regSource,    // Access source, gptm_pkg::gptm_src_t
  input  wire logic [8:0]  regAddr,      // Byte address
  input  wire logic [3:0]  regByteEn,    // Byte enables; halves may be read alone
  input  wire logic [31:0] regWdata,     // Write data
  output logic      [31:0] regRdata,     // Registered read data
  output logic             regRvalid,    // Read data valid pulse
  output logic             timerIrq,     // One-cycle timer event pulse
  output logic             readyIrq,     // One-cycle pulse when ready sets
  output logic             coreResetN,   // Core reset, active low
  output logic             emuPhyResetN, // Emulated PHY reset, active low
  output logic             phy1ResetN,   // First port PHY reset, active low
  output logic             phy2ResetN,   // Second port PHY reset, active low
  output logic             loaderReload, // Pulse: loader reloads configuration
  output logic             nvmAbort      // Pulse: abort configuration memory command
);
  // Package constants are used throughout the body
  import gptm_pkg::*;

  // Reset synchroniser and the soft reset derived from it
  logic        rstSync1_ff, rstSync2_ff;
  logic        rstN;
  logic        softRstN;

  // Countdown timer state
  logic        enable_ff, nxt_enable;
  logic [15:0] preload_ff, nxt_preload;
  logic [15:0] count_ff, nxt_count;
  logic        timerIrq_ff, nxt_timerIrq;

  // Free counter and its fractional phase
  logic [31:0] free_ff, nxt_free;
  logic [2:0]  frac_ff, nxt_frac;

  // Ready tracking after power-on or digital reset
  logic [3:0]  readyCnt_ff, nxt_readyCnt;
  logic        ready_ff, nxt_ready;
  logic        readyIrq_ff, nxt_readyIrq;

  // Registered read port
  logic [31:0] rdata_ff, nxt_rdata;
  logic        rvalid_ff, nxt_rvalid;

  // Write decode and self-clearing reset holders
  logic        hostWr, wrCfg, wrRst;
  logic        digBusy, emuBusy, p1Busy, p2Busy;
  logic        digBusyDly_ff;

  // Zeroes a 16-bit read half when both of its byte lanes are off
  function automatic logic [15:0] half_of(input logic [15:0] value, input logic [1:0] lanes);
    half_of = (lanes == 2'b00) ? 16'h0000 : value;
  endfunction : half_of

  // Reset release through two flops; assertion stays asynchronous
  // A synchronous release means no flop sees reset end close to its clock edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  // Everything but the input flops uses this synchronised copy
  assign rstN = rstSync2_ff;

  // Only host writes reach the reset bits; loader writes there are dropped
  // Configuration writes stay open to the loader; only the reset bits are closed to it
  assign hostWr = regWrite && (regSource == SRC_HOST);
  assign wrCfg  = regWrite && (regAddr == CFG_OFFSET);
  assign wrRst  = hostWr && (regAddr == SOFTWARE_RESET_CONTROL_OFFSET) && regByteEn[0];

  // Each reset bit starts a self-clearing hold; a write while busy is ignored inside.
  // The digital hold is short because only this block's registers sit behind it,
  // while the port PHY holds are long enough for each PHY's minimum reset time.
  // Digital reset: core registers only, the PHY holders stay out of it
  gptm_reset_pulse #(.HOLD(DIG_HOLD_CYCLES)) uDig (
    .clock (clock),
    .rstN  (rstN),
    .start (wrRst && regWdata[DIGITAL_RST_BIT]),
    .busy  (digBusy)
  );
  // Emulated PHY: short hold, it has no analogue part to settle
  gptm_reset_pulse #(.HOLD(EMU_HOLD_CYCLES)) uEmu (
    .clock (clock),
    .rstN  (rstN),
    .start (wrRst && regWdata[EMU_PHY_BIT]),
    .busy  (emuBusy)
  );
  // First port PHY: long minimum hold
  gptm_reset_pulse #(.HOLD(PHY_HOLD)) uPhy1 (
    .clock (clock),
    .rstN  (rstN),
    .start (wrRst && regWdata[FIRST_PHY_BIT]),
    .busy  (p1Busy)
  );
  // Second port PHY: same minimum hold as the first
  gptm_reset_pulse #(.HOLD(PHY_HOLD)) uPhy2 (
    .clock (clock),
    .rstN  (rstN),
    .start (wrRst && regWdata[SECOND_PHY_BIT]),
    .busy  (p2Busy)
  );

  // Soft reset covers the timer, free counter and ready registers, not the read port or the reset holders
  // Both terms come straight from flops, so the derived clear carries no decode glitches.
  // Each PHY line is low exactly while its bit reads one, so the bit and the line agree.
  assign softRstN     = rstN && !digBusy;
  assign coreResetN   = softRstN;
  assign emuPhyResetN = !emuBusy;
  assign phy1ResetN   = !p1Busy;
  assign phy2ResetN   = !p2Busy;

  // Digital reset start aborts NVM work; its release triggers a reload (never a PHY reset)
  // Both pulses last one cycle, taken from the edges of the busy flag
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      digBusyDly_ff <= 1'b0;
    end else begin
      digBusyDly_ff <= digBusy;
    end
  end
  assign nvmAbort     = digBusy && !digBusyDly_ff;
  assign loaderReload = !digBusy && digBusyDly_ff;

  // Countdown timer and its configuration.
  // Lane writes come first, then an enable fall forces the preload, so a preload
  // written together with clearing the enable is lost on purpose.
  always_comb begin
    nxt_enable   = enable_ff;
    nxt_preload  = preload_ff;
    nxt_count    = count_ff;
    nxt_timerIrq = 1'b0;
    if (wrCfg && regByteEn[3]) begin
      nxt_enable = regWdata[TIMER_EN_BIT];
    end
    if (wrCfg && regByteEn[0]) begin
      nxt_preload[7:0] = regWdata[7:0];
    end
    if (wrCfg && regByteEn[1]) begin
      nxt_preload[15:8] = regWdata[15:8];
    end
    if (enable_ff && !nxt_enable) begin
      nxt_preload = PRELOAD_RESET;
    end
    // Enable rise loads the count from the preload being written, if any
    if (!enable_ff && nxt_enable) begin
      nxt_count = nxt_preload;
    end else if (enable_ff) begin
      // The reload takes one cycle, so the period is the preload plus one
      if (count_ff == 16'h0000) begin
        nxt_count    = preload_ff;
        nxt_timerIrq = 1'b1;
      end else begin
        nxt_count = count_ff - 16'h0001;
      end
    end
  end

  // Timer state clears on power-on and on digital reset alike
  always_ff @(posedge clock or negedge softRstN) begin
    if (!softRstN) begin
      enable_ff   <= 1'b0;
      preload_ff  <= PRELOAD_RESET;
      count_ff    <= COUNT_RESET;
      timerIrq_ff <= 1'b0;
    end else begin
      enable_ff   <= nxt_enable;
      preload_ff  <= nxt_preload;
      count_ff    <= nxt_count;
      timerIrq_ff <= nxt_timerIrq;
    end
  end
  // The timer event leaves from a flop as a clean one-cycle pulse
  assign timerIrq = timerIrq_ff;

  // Free counter: adds one or two per clock so its mean rate is 25 MHz.
  // The phase steps 0,1,2,3: three steps of one, then one of two, five per four clocks.
  // The phase sum reaches eight, so it is kept one bit wider than the phase itself.
  always_comb begin
    logic [3:0] acc;
    acc      = {1'b0, frac_ff} + 4'(FREE_DIV_NUM);
    nxt_free = free_ff;
    nxt_frac = 3'(acc);
    if (acc >= 4'(2 * FREE_DIV_DEN)) begin
      nxt_frac = 3'(acc - 4'(2 * FREE_DIV_DEN));
      nxt_free = free_ff + 32'h2;
    end else if (acc >= 4'(FREE_DIV_DEN)) begin
      nxt_frac = 3'(acc - 4'(FREE_DIV_DEN));
      nxt_free = free_ff + 32'h1;
    end
  end

  // Clears asynchronously on reset, well inside 160 ns
  // The phase clears with the count so every run starts on the same step pattern
  always_ff @(posedge clock or negedge softRstN) begin
    if (!softRstN) begin
      free_ff <= FREE_RESET;
      frac_ff <= 3'h0;
    end else begin
      free_ff <= nxt_free;
      frac_ff <= nxt_frac;
    end
  end

  // Ready rises a few cycles after a power-on or digital reset settles; PHY resets leave it alone.
  // The byte test pattern and the ready bit both follow this flag, so a host that
  // polls either one sees the end of a digital reset in the same cycle.
  always_comb begin
    nxt_readyCnt = readyCnt_ff;
    nxt_ready    = ready_ff;
    nxt_readyIrq = 1'b0;
    // The wait counter stops once ready is set, so it never wraps
    if (!ready_ff) begin
      nxt_readyCnt = readyCnt_ff + 4'h1;
      if (readyCnt_ff == 4'(READY_DELAY - 1)) begin
        nxt_ready    = 1'b1;
        nxt_readyIrq = 1'b1;
      end
    end
  end

  // Register the ready tracking; a digital reset restarts the wait
  always_ff @(posedge clock or negedge softRstN) begin
    if (!softRstN) begin
      readyCnt_ff <= 4'h0;
      ready_ff    <= 1'b0;
      readyIrq_ff <= 1'b0;
    end else begin
      readyCnt_ff <= nxt_readyCnt;
      ready_ff    <= nxt_ready;
      readyIrq_ff <= nxt_readyIrq;
    end
  end
  // The ready event leaves from a flop as a clean one-cycle pulse
  assign readyIrq = readyIrq_ff;

  // Read mux; unselected halves read zero so a half can be read alone.
  // The hardware configuration word shows only the ready bit; its other fields live elsewhere.
  always_comb begin
    logic [31:0] word;
    word = 32'h0000_0000;
    // Unmapped addresses fall to the default and read zero
    unique case (regAddr)
      CFG_OFFSET:       word = {2'b00, enable_ff, 13'h0000, preload_ff};
      COUNT_OFFSET:     word = {16'h0000, count_ff};
      FREE_OFFSET:      word = free_ff;
      SOFTWARE_RESET_CONTROL_OFFSET: word = {28'h0000000, emuBusy, p2Busy, p1Busy, digBusy};
      BYTE_TEST_OFFSET: word = ready_ff ? BYTE_TEST_PATTERN : 32'h0000_0000;
      HW_CFG_OFFSET:    word = {4'h0, ready_ff, 27'h0000000};
      default:          word = 32'h0000_0000;
    endcase
    nxt_rdata  = {half_of(word[31:16], regByteEn[3:2]),
                  half_of(word[15:0], regByteEn[1:0])};
    // Valid follows the strobe one cycle later, whatever the address
    nxt_rvalid = regRead;
  end

  // Read port survives digital reset so polling during it is harmless
  // Data is captured every cycle; it means something only while valid stands
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rdata_ff  <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end
  // The read port leaves straight from its flops
  assign regRdata  = rdata_ff;
  assign regRvalid = rvalid_ff;
endmodule : gptm_misc_regs

// ### logic/gptm_pkg.sv
package gptm_pkg;
  // Register offsets (byte addresses)
  localparam logic [8:0]  CFG_OFFSET        = 9'h08C;
  localparam logic [8:0]  COUNT_OFFSET      = 9'h090;
  localparam logic [8:0]  FREE_OFFSET       = 9'h09C;
  localparam logic [8:0]  SOFTWARE_RESET_CONTROL_OFFSET  = 9'h1F8;
  localparam logic [8:0]  BYTE_TEST_OFFSET  = 9'h064;
  localparam logic [8:0]  HW_CFG_OFFSET     = 9'h074;
  // Field positions
  localparam int          TIMER_EN_BIT      = 29;
  localparam int          READY_BIT         = 27;
  localparam int          DIGITAL_RST_BIT   = 0;
  localparam int          FIRST_PHY_BIT     = 1;
  localparam int          SECOND_PHY_BIT    = 2;
  localparam int          EMU_PHY_BIT       = 3;
  // Reset values and fixed patterns
  localparam logic [15:0] PRELOAD_RESET     = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET       = 16'hFFFF;
  localparam logic [31:0] FREE_RESET        = 32'h0000_0000;
  localparam logic [31:0] BYTE_TEST_PATTERN = 32'h8765_4321;
  // Timing
  localparam int          CLOCK_MHZ         = 20;
  localparam int          PHY_HOLD_NS       = 102000;
  localparam int          PHY_HOLD_CYCLES   = (PHY_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int          DIG_HOLD_CYCLES   = 16;
  localparam int          EMU_HOLD_CYCLES   = 4;
  localparam int          READY_DELAY       = 8;
  // Register bus access sources
  typedef enum logic [1:0] {
    SRC_HOST   = 2'b01,
    SRC_LOADER = 2'b10
  } gptm_src_t;
endpackage : gptm_pkg

// ### logic/gptm_reset_pulse.sv
`timescale 1ns/1ps
// Self-clearing reset request: holds a reset line for a minimum time, then clears
module gptm_reset_pulse #(
  parameter int HOLD = 4          // Cycles of hold
) (
  input  wire logic clock,        // System clock
  input  wire logic rstN,         // Synchronised reset, active low
  input  wire logic start,        // One-cycle request
  output logic      busy          // Reset line and self-clearing bit
);
  logic [31:0] cnt_ff, nxt_cnt;
  logic        busy_ff, nxt_busy;

  // A start while busy is ignored, so the hold cannot be restarted
  always_comb begin
    nxt_busy = busy_ff;
    nxt_cnt  = cnt_ff;
    if (busy_ff) begin
      if (cnt_ff == 32'(HOLD - 1)) begin
        nxt_busy = 1'b0;
      end
      nxt_cnt = cnt_ff + 32'h1;
    end else if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt  = 32'h0;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 32'h0;
    end else begin
      busy_ff <= nxt_busy;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign busy = busy_ff;
endmodule : gptm_reset_pulse

// ### testbench/gp_timer_freerun_software_reset_control_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for timer, free counter and reset control
module gp_timer_freerun_software_reset_control_tb_top;
  import gptm_pkg::*;
  localparam int HOLD = 20; // Short PHY hold keeps the run brief
  logic        clock, resetn, regWrite, regRead, regRvalid, timerIrq, readyIrq, nvmAbort;
  logic        coreResetN, emuPhyResetN, phy1ResetN, phy2ResetN, loaderReload;
  logic [1:0]  regSource;
  logic [3:0]  regByteEn;
  logic [8:0]  regAddr;
  logic [31:0] regWdata, regRdata, a, b;
  logic        ok;
  int          errors, n_tests, n;
  gptm_misc_regs #(.PHY_HOLD(HOLD)) gptm_misc_regs_i (.clock(clock), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regSource(regSource), .regAddr(regAddr), .regByteEn(regByteEn), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid), .timerIrq(timerIrq), .readyIrq(readyIrq),
    .coreResetN(coreResetN), .emuPhyResetN(emuPhyResetN), .phy1ResetN(phy1ResetN), .phy2ResetN(phy2ResetN),
    .loaderReload(loaderReload), .nvmAbort(nvmAbort));
  gptm_host gptm_host_i (.clock(clock), .regWrite(regWrite), .regRead(regRead), .regSource(regSource),
    .regAddr(regAddr), .regByteEn(regByteEn), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid));
  // 20 MHz clock
  initial clock = 1'b0;
  always #25 clock = ~clock;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic flag(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask : flag
  // Waits for a line to reach a level, counting cycles
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (s !== v && n < 60);
  endtask : wait_for
  task automatic t_regs;
    gptm_host_i.rd(CFG_OFFSET, 4'hF, a);
    chk(a, {16'h0, PRELOAD_RESET});
    gptm_host_i.rd(COUNT_OFFSET, 4'hF, a);
    chk(a, {16'h0, COUNT_RESET});
    gptm_host_i.rd(CFG_OFFSET, 4'hC, a);
    chk(a, 32'h0);
    gptm_host_i.rd(9'h100, 4'hF, a);
    chk(a, 32'h0);
    gptm_host_i.rd(FREE_OFFSET, 4'hF, a);
    gptm_host_i.rd(FREE_OFFSET, 4'hF, b);
    flag(a < 32'h40);
    flag(b - a == 32'h2 || b - a == 32'h3);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_timer;
    gptm_host_i.wr(SRC_HOST, CFG_OFFSET, 4'hF, 32'h2000_0005);
    wait_for(timerIrq, 1'b1);
    flag(n < 60);
    wait_for(timerIrq, 1'b1);
    chk(n, 32'h6);
    gptm_host_i.wr(SRC_HOST, CFG_OFFSET, 4'hF, 32'h0000_0000);
    gptm_host_i.rd(CFG_OFFSET, 4'hF, a);
    chk(a, 32'h0000_FFFF);
    gptm_host_i.rd(COUNT_OFFSET, 4'hF, a);
    gptm_host_i.rd(COUNT_OFFSET, 4'hF, b);
    chk(b, a);
    flag(a <= 32'h5);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_phy;
    gptm_host_i.wr(SRC_LOADER, SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, 32'hF);
    gptm_host_i.rd(SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, a);
    chk(a, 32'h0);
    gptm_host_i.wr(SRC_HOST, SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, 32'h6);
    gptm_host_i.wr(SRC_HOST, SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, 32'h0);
    gptm_host_i.rd(SOFTWARE_RESET_CONTROL_OFFSET, 4'h3, a);
    chk(a, 32'h6);
    chk({30'h0, phy1ResetN, phy2ResetN}, 32'h0);
    wait_for(phy2ResetN, 1'b1);
    flag(n < 60 && phy1ResetN === 1'b1);
    gptm_host_i.rd(SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, a);
    chk(a, 32'h0);
    gptm_host_i.wr(SRC_HOST, SOFTWARE_RESET_CONTROL_OFFSET, 4'h1, 32'h8);
    #1;
    chk({29'h0, emuPhyResetN, coreResetN, phy1ResetN}, 32'h3);
    repeat (8) @(posedge clock);
    gptm_host_i.rd(SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, a);
    chk(a, 32'h0);
    $display("t_phy done");
  endtask : t_phy
  task automatic t_dig;
    gptm_host_i.wr(SRC_HOST, CFG_OFFSET, 4'hF, 32'h0000_1234);
    gptm_host_i.wr(SRC_HOST, SOFTWARE_RESET_CONTROL_OFFSET, 4'h1, 32'h1);
    #1;
    chk({28'h0, coreResetN, phy1ResetN, phy2ResetN, emuPhyResetN}, 32'h7);
    flag(nvmAbort);
    wait_for(loaderReload, 1'b1);
    flag(n < 60);
    wait_for(readyIrq, 1'b1);
    chk(n, READY_DELAY);
    gptm_host_i.poll(BYTE_TEST_OFFSET, BYTE_TEST_PATTERN, ok);
    flag(ok);
    gptm_host_i.rd(CFG_OFFSET, 4'hF, a);
    chk(a, 32'h0000_FFFF);
    gptm_host_i.rd(HW_CFG_OFFSET, 4'hF, a);
    flag(a[READY_BIT]);
    gptm_host_i.rd(SOFTWARE_RESET_CONTROL_OFFSET, 4'hF, a);
    chk(a, 32'h0);
    $display("t_dig done");
  endtask : t_dig
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Main sequence after an 8-cycle reset
  initial begin
    errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (12) @(posedge clock);
    t_regs();
    t_timer();
    t_phy();
    t_dig();
    conclude();
  end
  // Watchdog: tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    errors++;
    conclude();
  end
endmodule : gp_timer_freerun_software_reset_control_tb_top

// ### testbench/gptm_host.sv
`timescale 1ns/1ps
// Host processor on the register bus
module gptm_host (
  input  wire logic        clock,     // System clock
  output logic             regWrite,  // Write strobe
  output logic             regRead,   // Read strobe
  output logic [1:0]       regSource, // Requester
  output logic [8:0]       regAddr,   // Byte address
  output logic [3:0]       regByteEn, // Lane enables
  output logic [31:0]      regWdata,  // Write data
  input  wire logic [31:0] regRdata,  // Read data
  input  wire logic        regRvalid  // Read data valid
);
  // Idle bus at time zero
  initial begin
    {regWrite, regRead, regSource, regAddr, regByteEn, regWdata} = '0;
  end
  // One strobe cycle; address and data are scrambled after so stale values never match
  task automatic req(input logic w, input logic [1:0] s, input logic [8:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge clock);
    regWrite  <= w;
    regRead   <= !w;
    regSource <= s;
    regAddr   <= a;
    regByteEn <= b;
    regWdata  <= d;
    @(posedge clock);
    regWrite  <= 1'b0;
    regRead   <= 1'b0;
    regAddr   <= ~a;
    regWdata  <= ~d;
  endtask : req
  task automatic wr(input logic [1:0] s, input logic [8:0] a, input logic [3:0] b, input logic [31:0] d);
    req(1'b1, s, a, b, d);
  endtask : wr
  // Data without its valid flag is treated as unknown
  task automatic rd(input logic [8:0] a, input logic [3:0] b, output logic [31:0] d);
    req(1'b0, 2'b01, a, b, 32'h0);
    #1;
    d = (regRvalid === 1'b1) ? regRdata : 32'hX;
  endtask : rd
  // Poll until the pattern shows, bounded
  task automatic poll(input logic [8:0] a, input logic [31:0] p, output logic ok);
    logic [31:0] d;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      rd(a, 4'hF, d);
      ok = (d === p);
    end
  endtask : poll
endmodule : gptm_host

// ### testbench/gptm_misc_chk.sv
`timescale 1ns/1ps
// Port-level checks of the timer and reset control block
module gptm_misc_chk #(
  parameter int PHY_HOLD = 20     // Port PHY hold cycles
) (
  input wire logic clock,         // System clock
  input wire logic resetn,        // Reset, active low
  input wire logic regRead,       // Read strobe
  input wire logic regRvalid,     // Read data valid
  input wire logic timerIrq,      // Timer event
  input wire logic readyIrq,      // Ready event
  input wire logic coreResetN,    // Core reset
  input wire logic emuPhyResetN,  // Emulated PHY reset
  input wire logic phy1ResetN,    // First PHY reset
  input wire logic phy2ResetN,    // Second PHY reset
  input wire logic loaderReload,  // Loader reload pulse
  input wire logic nvmAbort       // Abort pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  int low1_ff, low2_ff, nxt_low1, nxt_low2;
  // Length of each PHY reset; a hold too short would leave the PHY half cleared
  always_comb begin
    nxt_low1 = phy1ResetN ? 0 : low1_ff + 1;
    nxt_low2 = phy2ResetN ? 0 : low2_ff + 1;
  end
  // Register the hold counters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low1_ff <= 0;
      low2_ff <= 0;
    end else begin
      low1_ff <= nxt_low1;
      low2_ff <= nxt_low2;
    end
  end
  // Bus, events and reset lines
  read_answer_a: assert property (regRead |=> regRvalid) else $error("read not answered");
  rvalid_cause_a: assert property (regRvalid |-> $past(regRead)) else $error("stray rvalid");
  timer_pulse_a: assert property (timerIrq |=> !timerIrq) else $error("timer event too long");
  ready_pulse_a: assert property (readyIrq |=> !readyIrq) else $error("ready event too long");
  phy1_hold_a: assert property ($rose(phy1ResetN) |-> low1_ff >= PHY_HOLD) else $error("phy1 hold short");
  phy2_hold_a: assert property ($rose(phy2ResetN) |-> low2_ff >= PHY_HOLD) else $error("phy2 hold short");
  phy_release_a: assert property (low1_ff <= PHY_HOLD + 8) else $error("phy1 never released");
  emu_hold_a: assert property ($fell(emuPhyResetN) |-> !emuPhyResetN [*3] ##[1:8] emuPhyResetN)
    else $error("emulated phy reset length");
  core_hold_a: assert property ($fell(coreResetN) |-> !coreResetN [*8] ##[1:20] coreResetN)
    else $error("digital reset length");
  abort_core_a: assert property (nvmAbort |-> ##[0:1] !coreResetN) else $error("abort without reset");
  reload_rel_a: assert property (loaderReload |-> $past(!coreResetN) || $past(!coreResetN, 2))
    else $error("reload not at release");
  phys_kept_a: assert property ($fell(coreResetN) && phy1ResetN && phy2ResetN && emuPhyResetN
    |-> (phy1ResetN && phy2ResetN && emuPhyResetN) [*8]) else $error("digital reset hit phys");
  // Main scenarios seen
  cover property (timerIrq);
  cover property ($rose(phy2ResetN));
  cover property (loaderReload);
endmodule : gptm_misc_chk

bind gptm_misc_regs gptm_misc_chk #(.PHY_HOLD(PHY_HOLD)) gptm_misc_chk_i (
  .clock(clock), .resetn(resetn), .regRead(regRead), .regRvalid(regRvalid), .timerIrq(timerIrq),
  .readyIrq(readyIrq), .coreResetN(coreResetN), .emuPhyResetN(emuPhyResetN), .phy1ResetN(phy1ResetN),
  .phy2ResetN(phy2ResetN), .loaderReload(loaderReload), .nvmAbort(nvmAbort));
